// >>> rtl/pms_pkg.sv
// constants, types and decode helpers of the mode sequencer
package pms_pkg;
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_SLEEP  = 2'h0;
  localparam logic [MODE_W-1:0] MODE_NORMAL = 2'h3;
  localparam int CLK_FREQ_HZ  = 25000000;
  localparam int BASE_FREQ_HZ = 200;
  localparam int BASE_TICK_CYCLES = CLK_FREQ_HZ / BASE_FREQ_HZ;
  localparam int ADC_W  = 16;
  localparam int OSR_W  = 3;
  localparam int DATA_W = 24;
  localparam int COEF_W = 7;
  localparam int ODR_W  = 5;
  localparam int PER_W  = 18;
  localparam logic [OSR_W-1:0] OSR_MAX = 3'h5;
  localparam logic [ODR_W-1:0] ODR_MAX = 5'h11;

  typedef enum logic [4:0] {
    ST_SLEEP   = 5'h01,
    ST_TEMP    = 5'h02,
    ST_PRESS   = 5'h04,
    ST_FILT    = 5'h08,
    ST_STANDBY = 5'h10
  } pms_state_type;

  typedef enum logic [1:0] {
    PM_SLEEP  = 2'h0,
    PM_FORCED = 2'h1,
    PM_NORMAL = 2'h2
  } pms_pmode_type;

  // both middle codes select forced
  function automatic pms_pmode_type pms_decode(input logic [MODE_W-1:0] f);
    pms_pmode_type m;
    m = PM_FORCED;
    if (f == MODE_SLEEP) m = PM_SLEEP;
    if (f == MODE_NORMAL) m = PM_NORMAL;
    return m;
  endfunction

  // sleep reaches any mode, normal only sleep or normal, forced ends by itself
  function automatic logic pms_legal(input pms_pmode_type c, input pms_pmode_type n);
    return (c == PM_SLEEP) || ((c == PM_NORMAL) && (n != PM_FORCED));
  endfunction
endpackage

// >>> rtl/pms_ovs_acc.sv
// oversampling accumulator for one conversion
`timescale 1ns/100ps
`default_nettype none
module pms_ovs_acc #(
  parameter int AW = pms_pkg::ADC_W,
  parameter int OW = pms_pkg::OSR_W,
  parameter int DW = pms_pkg::DATA_W
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // control
  input  wire logic          start,
  input  wire logic [OW-1:0] osr,
  // sample stream
  output logic               smp_req,
  input  wire logic          smp_valid,
  input  wire logic [AW-1:0] smp_data,
  // result
  output logic               done,
  output logic [DW-1:0]      result
);
  import pms_pkg::*;
  localparam int CW = 2 ** OW;

  logic          busy_q;
  logic [OW-1:0] osr_q;
  logic [CW-1:0] cnt_q;
  logic [DW-1:0] sum_q;

  wire [DW-1:0] sum_d = sum_q + DW'(smp_data);
  wire [CW-1:0] need  = CW'(1) << osr_q;
  wire          last  = smp_valid && (cnt_q == need - CW'(1));
  wire [OW-1:0] osr_c = (osr > OSR_MAX) ? OSR_MAX : osr;

  assign smp_req = busy_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      osr_q  <= '0;
      cnt_q  <= '0;
      sum_q  <= '0;
      done   <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        osr_q  <= osr_c;
        cnt_q  <= '0;
        sum_q  <= '0;
      end else if (busy_q && smp_valid) begin
        sum_q <= sum_d;
        cnt_q <= cnt_q + CW'(1);
        if (last) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
          result <= sum_d << (DW - AW - int'(osr_q));
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/pms_iir.sv
// single channel iir stage with serial divider
`timescale 1ns/100ps
`default_nettype none
module pms_iir #(
  parameter int DW = pms_pkg::DATA_W,
  parameter int CW = pms_pkg::COEF_W
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // control
  input  wire logic          clear,
  input  wire logic          start,
  input  wire logic [CW-1:0] coef,
  input  wire logic [DW-1:0] din,
  // result
  output logic               busy,
  output logic               done,
  output logic [DW-1:0]      dout
);
  import pms_pkg::*;
  localparam int NW = DW + CW + 1;
  localparam int KW = $clog2(NW + 1);

  logic          primed_q;
  logic [NW-1:0] num_q;
  logic [CW:0]   den_q;
  logic [CW:0]   rem_q;
  logic [KW-1:0] cnt_q;

  wire [NW-1:0] prod   = NW'(dout) * NW'(coef) + NW'(din);
  wire [CW+1:0] rem_sh = {rem_q, num_q[NW-1]};
  wire          take   = rem_sh >= {1'b0, den_q};
  wire [CW+1:0] rem_df = rem_sh - {1'b0, den_q};
  wire [NW-1:0] quo_d  = {num_q[NW-2:0], take};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      primed_q <= 1'b0;
      busy     <= 1'b0;
      done     <= 1'b0;
      dout     <= '0;
      num_q    <= '0;
      den_q    <= '0;
      rem_q    <= '0;
      cnt_q    <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        // first value after a clear seeds the filter memory
        if (clear || !primed_q || (coef == '0)) begin
          dout     <= din;
          done     <= 1'b1;
          primed_q <= 1'b1;
        end else begin
          busy  <= 1'b1;
          num_q <= prod;
          den_q <= (CW+1)'(coef) + (CW+1)'(1);
          rem_q <= '0;
          cnt_q <= '0;
        end
      end else if (clear) begin
        primed_q <= 1'b0;
      end else if (busy) begin
        rem_q <= take ? rem_df[CW:0] : rem_sh[CW:0];
        num_q <= quo_d;
        cnt_q <= cnt_q + KW'(1);
        if (cnt_q == KW'(NW - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
          dout <= quo_d[DW-1:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/pms_sequencer.sv
// power mode and measurement sequencer of the pressure sensor
`timescale 1ns/100ps
`default_nettype none
module pms_sequencer #(
  parameter int TICK_CYCLES = pms_pkg::BASE_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // power control
  input  wire logic                       mode_wr,
  input  wire logic [pms_pkg::MODE_W-1:0] mode_wdata,
  output logic [pms_pkg::MODE_W-1:0]      mode_rd,
  output logic                            mode_pend,
  output logic                            mode_drop,
  // measurement configuration
  input  wire logic                       temp_en,
  input  wire logic                       press_en,
  input  wire logic [pms_pkg::OSR_W-1:0]  osr_t,
  input  wire logic [pms_pkg::OSR_W-1:0]  osr_p,
  input  wire logic [pms_pkg::ODR_W-1:0]  odr_sel,
  input  wire logic [pms_pkg::COEF_W-1:0] iir_coef,
  input  wire logic                       iir_wr,
  output logic                            cfg_err,
  // reset status
  input  wire logic                       soft_rst,
  input  wire logic                       por_rd,
  output logic                            por_flag,
  // conversion front end
  output logic                            adc_req,
  output logic                            adc_press,
  input  wire logic                       adc_valid,
  input  wire logic [pms_pkg::ADC_W-1:0]  adc_sample,
  // results
  output logic [pms_pkg::DATA_W-1:0]      temp_data,
  output logic [pms_pkg::DATA_W-1:0]      press_data,
  output logic                            data_rdy,
  output logic                            meas_busy
);
  import pms_pkg::*;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  pms_state_type     state_q;
  pms_state_type     state_d;
  pms_state_type     first_st;
  pms_pmode_type     base_pm;
  pms_pmode_type     ap_pm;

  logic [MODE_W-1:0] mode_q;
  logic [MODE_W-1:0] mode_d;
  logic [MODE_W-1:0] base_mode;
  logic [MODE_W-1:0] ap_m;
  logic [MODE_W-1:0] pend_mode_q;
  logic              pend_q;
  logic              drop_q;
  logic              t_meas_q;
  logic              p_meas_q;
  logic              filt_go_q;
  logic              chan_q;
  logic              temp_en_q;
  logic              press_en_q;
  logic              por_q;
  logic              rdy_q;
  logic [DATA_W-1:0] t_raw_q;
  logic [DATA_W-1:0] p_raw_q;
  logic [DATA_W-1:0] temp_q;
  logic [DATA_W-1:0] press_q;
  logic [TW-1:0]     tick_q;
  logic [PER_W-1:0]  per_q;
  logic              per_done_q;

  logic              acc_go;
  logic              acc_chan;
  logic [OSR_W-1:0]  acc_osr;
  logic              acc_done;
  logic [DATA_W-1:0] acc_res;
  logic              iir_clr;
  logic              t_busy;
  logic              t_done;
  logic [DATA_W-1:0] t_out;
  logic              p_busy;
  logic              p_done;
  logic [DATA_W-1:0] p_out;

  // state decode
  wire in_sleep = (state_q == ST_SLEEP);
  wire in_stby  = (state_q == ST_STANDBY);
  wire in_temp  = (state_q == ST_TEMP);
  wire in_press = (state_q == ST_PRESS);
  wire in_filt  = (state_q == ST_FILT);
  wire busy     = in_temp | in_press | in_filt;

  // the filter stage is done once its start pulse has passed and both channels are idle
  wire filt_idle = !filt_go_q && !t_busy && !p_busy;
  wire end_meas  = in_filt && filt_idle;
  wire forced_q  = (pms_decode(mode_q) == PM_FORCED);

  // forced falls back to sleep as the period closes
  assign base_mode = (end_meas && forced_q) ? MODE_SLEEP : mode_q;

  // requests act at once when idle, else at the end of the period
  wire ap_v = end_meas ? (pend_q | mode_wr) : ((in_sleep | in_stby) & mode_wr);

  // a waiting request beats a write landing on the closing cycle
  assign ap_m = (end_meas && pend_q) ? pend_mode_q : mode_wdata;

  assign base_pm = pms_decode(base_mode);
  assign ap_pm   = pms_decode(ap_m);

  wire ap_ok = ap_v && pms_legal(base_pm, ap_pm);
  assign mode_d = ap_ok ? ap_m : base_mode;

  // normal-mode period in base ticks, codes above the top are clamped
  wire [ODR_W-1:0] odr_eff  = (odr_sel > ODR_MAX) ? ODR_MAX : odr_sel;
  wire [PER_W-1:0] presc    = PER_W'(1) << odr_eff;
  wire             tick_end = (tick_q == TW'(TICK_CYCLES - 1));
  wire             per_end  = tick_end && (per_q == presc - PER_W'(1));

  // leaving sleep starts a measurement right away
  wire wake     = ap_ok && (base_pm == PM_SLEEP) && (ap_pm != PM_SLEEP);
  wire go_sleep = (pms_decode(mode_d) == PM_SLEEP);
  // restart on the closing tick itself, the flag alone would add a cycle
  wire per_hit  = in_stby && (per_done_q || per_end) && !go_sleep;
  wire meas_go  = wake | per_hit;

  // a write while busy is parked, applied on the closing cycle, or dropped
  wire defer = busy && !end_meas && mode_wr && !pend_q;
  wire lost  = busy && mode_wr && pend_q;
  wire bad   = ap_v && !ap_ok;

  // temperature first, pressure second, either may be skipped
  assign first_st = temp_en ? ST_TEMP : (press_en ? ST_PRESS : ST_FILT);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SLEEP: begin
        if (meas_go) begin
          state_d = first_st;
        end
      end
      ST_STANDBY: begin
        if (meas_go) begin
          state_d = first_st;
        end else if (go_sleep) begin
          state_d = ST_SLEEP;
        end
      end
      ST_TEMP: begin
        if (acc_done) begin
          state_d = p_meas_q ? ST_PRESS : ST_FILT;
        end
      end
      ST_PRESS: begin
        if (acc_done) begin
          state_d = ST_FILT;
        end
      end
      ST_FILT: begin
        if (end_meas) begin
          if (meas_go) begin
            state_d = first_st;
          end else if (go_sleep) begin
            state_d = ST_SLEEP;
          end else begin
            state_d = ST_STANDBY;
          end
        end
      end
      default: begin
        state_d = ST_SLEEP;
      end
    endcase
  end

  // conversion launch and channel choice
  assign acc_go   = (meas_go && (temp_en || press_en)) || (in_temp && acc_done && p_meas_q);
  assign acc_chan = meas_go ? !temp_en : 1'b1;
  assign acc_osr  = acc_chan ? osr_p : osr_t;

  // filter memory is dropped on coefficient write, soft reset, enable fall or sleep to normal
  assign iir_clr = iir_wr | soft_rst
                 | (temp_en_q & !temp_en)
                 | (press_en_q & !press_en)
                 | (wake && (ap_pm == PM_NORMAL));

  // state and mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_SLEEP;
      mode_q  <= MODE_SLEEP;
    end else if (soft_rst) begin
      state_q <= ST_SLEEP;
      mode_q  <= MODE_SLEEP;
    end else begin
      state_q <= state_d;
      mode_q  <= mode_d;
    end
  end

  // parked mode request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_q      <= 1'b0;
      pend_mode_q <= MODE_SLEEP;
      drop_q      <= 1'b0;
    end else if (soft_rst) begin
      pend_q      <= 1'b0;
      pend_mode_q <= MODE_SLEEP;
      drop_q      <= 1'b0;
    end else begin
      drop_q <= lost | bad;
      if (end_meas) begin
        pend_q <= 1'b0;
      end else if (defer) begin
        pend_q      <= 1'b1;
        pend_mode_q <= mode_wdata;
      end
    end
  end

  // per-measurement bookkeeping
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      t_meas_q   <= 1'b0;
      p_meas_q   <= 1'b0;
      filt_go_q  <= 1'b0;
      chan_q     <= 1'b0;
      temp_en_q  <= 1'b0;
      press_en_q <= 1'b0;
    end else begin
      temp_en_q  <= temp_en;
      press_en_q <= press_en;
      filt_go_q  <= (state_d == ST_FILT) && !in_filt;
      if (meas_go) begin
        t_meas_q <= temp_en;
        p_meas_q <= press_en;
      end
      if (acc_go) begin
        chan_q <= acc_chan;
      end
    end
  end

  // raw conversion results
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      t_raw_q <= '0;
      p_raw_q <= '0;
    end else if (acc_done) begin
      if (chan_q) begin
        p_raw_q <= acc_res;
      end else begin
        t_raw_q <= acc_res;
      end
    end
  end

  // base tick and period counters, restarted at every measurement
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_q     <= '0;
      per_q      <= '0;
      per_done_q <= 1'b0;
    end else if (meas_go || soft_rst) begin
      tick_q     <= '0;
      per_q      <= '0;
      per_done_q <= 1'b0;
    end else begin
      tick_q <= tick_end ? '0 : tick_q + TW'(1);
      if (per_end) begin
        per_done_q <= 1'b1;
      end
      if (tick_end && !per_done_q) begin
        per_q <= per_q + PER_W'(1);
      end
    end
  end

  // published data, kept until the next filtered value or a soft reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      temp_q  <= '0;
      press_q <= '0;
      rdy_q   <= 1'b0;
    end else if (soft_rst) begin
      temp_q  <= '0;
      press_q <= '0;
      rdy_q   <= 1'b0;
    end else begin
      rdy_q <= end_meas;
      if (t_done) begin
        temp_q <= t_out;
      end
      if (p_done) begin
        press_q <= p_out;
      end
    end
  end

  // reset-done flag: a new reset beats a read in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      por_q <= 1'b1;
    end else if (soft_rst) begin
      por_q <= 1'b1;
    end else if (por_rd) begin
      por_q <= 1'b0;
    end
  end

  pms_ovs_acc u_acc (
    .core_clk  (core_clk),
    .rst       (rst),
    .start     (acc_go),
    .osr       (acc_osr),
    .smp_req   (adc_req),
    .smp_valid (adc_valid),
    .smp_data  (adc_sample),
    .done      (acc_done),
    .result    (acc_res)
  );

  pms_iir u_iir_t (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (iir_clr),
    .start    (filt_go_q & t_meas_q),
    .coef     (iir_coef),
    .din      (t_raw_q),
    .busy     (t_busy),
    .done     (t_done),
    .dout     (t_out)
  );

  pms_iir u_iir_p (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (iir_clr),
    .start    (filt_go_q & p_meas_q),
    .coef     (iir_coef),
    .din      (p_raw_q),
    .busy     (p_busy),
    .done     (p_done),
    .dout     (p_out)
  );

  // status and data outputs
  assign mode_rd    = mode_q;
  assign mode_pend  = pend_q;
  assign mode_drop  = drop_q;
  assign cfg_err    = (odr_sel > ODR_MAX) || (osr_t > OSR_MAX) || (osr_p > OSR_MAX);
  assign por_flag   = por_q;
  assign adc_press  = chan_q;
  assign temp_data  = temp_q;
  assign press_data = press_q;
  assign data_rdy   = rdy_q;
  assign meas_busy  = busy;
endmodule
`default_nettype wire

// >>> test/pms_sequencer_properties.sv
// port assertions of the mode sequencer
`timescale 1ns/100ps
`default_nettype none
module pms_sequencer_properties (
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst,
  // mode and status
  input wire logic                       mode_wr,
  input wire logic [pms_pkg::MODE_W-1:0] mode_wdata,
  input wire logic [pms_pkg::MODE_W-1:0] mode_rd,
  input wire logic                       mode_pend,
  input wire logic                       mode_drop,
  input wire logic                       temp_en,
  input wire logic                       press_en,
  input wire logic                       soft_rst,
  input wire logic                       por_rd,
  input wire logic                       por_flag,
  // measurement
  input wire logic                       adc_req,
  input wire logic                       adc_press,
  input wire logic                       data_rdy,
  input wire logic                       meas_busy
);
  import pms_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // a leftover conversion after soft reset is not idle
  wire logic idle = (mode_rd == MODE_SLEEP) && !meas_busy && !adc_req && !soft_rst;

  a_sleep_quiet: assert property (idle && !mode_wr |=> !adc_req)
    else $error("request while asleep");
  a_forced_start: assert property (
    idle && mode_wr && temp_en && (mode_wdata inside {2'h1, 2'h2})
    |=> (mode_rd inside {2'h1, 2'h2}) && meas_busy && adc_req && !adc_press)
    else $error("forced did not start");
  a_normal_start: assert property (idle && mode_wr && mode_wdata == MODE_NORMAL |=> mode_rd == MODE_NORMAL)
    else $error("normal not entered");
  a_pend_cause: assert property ($rose(mode_pend) |-> $past(mode_wr && meas_busy))
    else $error("parked without busy write");
  a_pend_busy: assert property (mode_pend |-> meas_busy)
    else $error("parked outside measurement");
  a_drop_second: assert property (mode_pend && mode_wr && !soft_rst |=> mode_drop)
    else $error("second request kept");
  a_forced_idle: assert property (!meas_busy |-> !(mode_rd inside {2'h1, 2'h2}))
    else $error("forced mode idle");
  a_rdy_after: assert property (data_rdy |-> $past(meas_busy) && !$past(data_rdy))
    else $error("ready without period");
  a_por_read: assert property (por_rd && !soft_rst |=> !por_flag)
    else $error("flag not cleared");
  a_soft_reset: assert property (soft_rst |=> por_flag && mode_rd == MODE_SLEEP && !mode_pend)
    else $error("soft reset incomplete");
  a_press_skip: assert property ($rose(adc_press) |-> $past(press_en))
    else $error("pressure while disabled");

  cover property (mode_pend && mode_wr);
  cover property (data_rdy && mode_rd == MODE_NORMAL);
  cover property ($rose(adc_press));
endmodule

bind pms_sequencer pms_sequencer_properties chk (
  .core_clk(core_clk), .rst(rst), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
  .mode_rd(mode_rd), .mode_pend(mode_pend), .mode_drop(mode_drop), .temp_en(temp_en),
  .press_en(press_en), .soft_rst(soft_rst), .por_rd(por_rd), .por_flag(por_flag),
  .adc_req(adc_req), .adc_press(adc_press), .data_rdy(data_rdy), .meas_busy(meas_busy)
);
`default_nettype wire

// >>> test/pms_adc_model.sv
// conversion front end model answering sample requests
`timescale 1ns/100ps
`default_nettype none
module pms_adc_model (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // request side
  input  wire logic                      adc_req,
  input  wire logic                      adc_press,
  // bench control
  input  wire logic                      slow,
  input  wire logic [pms_pkg::ADC_W-1:0] t_val,
  input  wire logic [pms_pkg::ADC_W-1:0] p_val,
  // sample side
  output logic                           adc_valid,
  output logic [pms_pkg::ADC_W-1:0]      adc_sample
);
  import pms_pkg::*;
  logic [1:0]       gap_q;
  logic [ADC_W-1:0] last_q;
  // slow mode offers one sample in three cycles
  assign adc_valid  = adc_req && (!slow || gap_q == 2'h0);
  // no stale copy between samples, the bus keeps toggling
  assign adc_sample = adc_valid ? (adc_press ? p_val : t_val) : ~last_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_q  <= 2'h0;
      last_q <= 16'h0;
    end else begin
      gap_q  <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
      last_q <= adc_sample;
    end
  end
endmodule
`default_nettype wire

// >>> test/pms_sequencer_bench.sv
// self-checking bench of the mode sequencer
`timescale 1ns/100ps
`default_nettype none
module pms_sequencer_bench;
  import pms_pkg::*;
  localparam int TICK = 8;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic              mode_wr = 1'b0;
  logic              temp_en = 1'b1;
  logic              press_en = 1'b1;
  logic              iir_wr = 1'b0;
  logic              soft_rst = 1'b0;
  logic              por_rd = 1'b0;
  logic              slow = 1'b0;
  logic [MODE_W-1:0] mode_wdata = 2'h0;
  logic [MODE_W-1:0] mode_rd;
  logic [OSR_W-1:0]  osr_t = 3'h0;
  logic [OSR_W-1:0]  osr_p = 3'h0;
  logic [ODR_W-1:0]  odr_sel = 5'h2;
  logic [COEF_W-1:0] iir_coef = 7'h0;
  logic [ADC_W-1:0]  t_val = 16'h1234;
  logic [ADC_W-1:0]  p_val = 16'h5678;
  logic [ADC_W-1:0]  adc_sample;
  logic [DATA_W-1:0] temp_data;
  logic [DATA_W-1:0] press_data;
  logic              mode_pend, mode_drop, cfg_err, por_flag, adc_req, adc_press;
  logic              adc_valid, data_rdy, meas_busy;
  int                err_total = 0;
  int                check_count = 0;
  int                nt = 0;
  int                np = 0;
  int                order_bad = 0;

  always #20 core_clk = ~core_clk;

  pms_sequencer #(.TICK_CYCLES(TICK)) uut (
    .core_clk(core_clk), .rst(rst), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
    .mode_rd(mode_rd), .mode_pend(mode_pend), .mode_drop(mode_drop), .temp_en(temp_en),
    .press_en(press_en), .osr_t(osr_t), .osr_p(osr_p), .odr_sel(odr_sel),
    .iir_coef(iir_coef), .iir_wr(iir_wr), .cfg_err(cfg_err), .soft_rst(soft_rst),
    .por_rd(por_rd), .por_flag(por_flag), .adc_req(adc_req), .adc_press(adc_press),
    .adc_valid(adc_valid), .adc_sample(adc_sample), .temp_data(temp_data),
    .press_data(press_data), .data_rdy(data_rdy), .meas_busy(meas_busy)
  );

  pms_adc_model adc (
    .core_clk(core_clk), .rst(rst), .adc_req(adc_req), .adc_press(adc_press), .slow(slow),
    .t_val(t_val), .p_val(p_val), .adc_valid(adc_valid), .adc_sample(adc_sample)
  );

  // samples per channel, seen at the falling edge where the request is settled
  always @(negedge core_clk) begin
    if (adc_req === 1'b1 && adc_valid === 1'b1) begin
      if (adc_press) np++;
      else begin
        nt++;
        if (np != 0) order_bad = 1;
      end
    end
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
                       input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // returns in the cycle after the taking edge, where answers are visible
  task automatic wr_mode(input logic [1:0] v);
    cyc(1);
    mode_wr = 1'b1;
    mode_wdata = v;
    cyc(1);
    mode_wr = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic wait_rdy(output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (data_rdy !== 1'b1 && n < 3000);
    if (n >= 3000) check(1, 0, "ready timeout");
  endtask

  task automatic t_reset();
    @(negedge core_clk);
    check(mode_rd, MODE_SLEEP, "mode");
    check(por_flag, 1, "flag");
    check(temp_data, 0, "data");
    check(meas_busy, 0, "busy");
    cyc(20);
    check(nt + np, 0, "sleep samples");
    por_rd = 1'b1;
    cyc(1);
    por_rd = 1'b0;
    check(por_flag, 0, "flag read");
    soft_rst = 1'b1;
    cyc(1);
    soft_rst = 1'b0;
    check(por_flag, 1, "flag soft");
    check(cfg_err, 0, "config ok");
    odr_sel = 5'h12;
    cyc(1);
    check(cfg_err, 1, "prescaler range");
    odr_sel = 5'h2;
  endtask

  task automatic t_forced(input logic [2:0] ot, input logic [2:0] op, input logic pe,
                          input logic [1:0] code);
    int n;
    cyc(1);
    osr_t = ot;
    osr_p = op;
    press_en = pe;
    nt = 0;
    np = 0;
    order_bad = 0;
    wr_mode(code);
    wait_rdy(n);
    check(mode_rd, MODE_SLEEP, "mode after forced");
    check(nt, 1 << ot, "temp samples");
    check(np, pe ? (1 << op) : 0, "press samples");
    check(order_bad, 0, "order");
    check(temp_data, {t_val, 8'h00}, "temp result");
    if (pe) check(press_data, {p_val, 8'h00}, "press result");
    cyc(30);
    check(nt, 1 << ot, "single run");
  endtask

  task automatic t_normal();
    int n;
    cyc(1);
    slow = 1'b1;
    osr_t = 3'h2;
    osr_p = 3'h2;
    press_en = 1'b1;
    wr_mode(2'h1);
    wr_mode(MODE_NORMAL);
    check(mode_pend, 1, "parked");
    check(mode_rd, 2'h1, "mode busy");
    wr_mode(MODE_SLEEP);
    check(mode_drop, 1, "dropped");
    wait_rdy(n);
    check(mode_rd, MODE_NORMAL, "parked applied");
    cyc(1);
    slow = 1'b0;
    for (int k = 2; k < 4; k++) begin
      cyc(1);
      odr_sel = 5'(k);
      t_val = 16'h0a00 + 16'(k);
      wait_rdy(n);
      wait_rdy(n);
      wait_rdy(n);
      check(n, (1 << k) * TICK, "period");
      check(temp_data, {t_val, 8'h00}, "fresh");
    end
    wr_mode(2'h1);
    check(mode_drop, 1, "illegal drop");
    check(mode_rd, MODE_NORMAL, "mode kept");
    wr_mode(MODE_SLEEP);
    check(mode_rd, MODE_SLEEP, "to sleep");
  endtask

  task automatic t_iir();
    int n;
    cyc(1);
    press_en = 1'b0;
    osr_t = 3'h0;
    iir_coef = 7'h1;
    iir_wr = 1'b1;
    t_val = 16'h1000;
    cyc(1);
    iir_wr = 1'b0;
    wr_mode(2'h2);
    wait_rdy(n);
    check(temp_data, 24'h100000, "filter seed");
    cyc(1);
    t_val = 16'h3000;
    wr_mode(2'h1);
    wait_rdy(n);
    check(temp_data, 24'h200000, "filtered");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    err_total++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    t_reset();
    t_forced(3'h0, 3'h5, 1'b1, 2'h1);
    t_forced(3'h5, 3'h0, 1'b1, 2'h2);
    t_forced(3'h3, 3'h2, 1'b1, 2'h1);
    t_forced(3'h1, 3'h1, 1'b0, 2'h2);
    t_normal();
    t_iir();
    end_sim();
  end
endmodule
`default_nettype wire
